// *** rtl/irq_bank.sv ***
// Functional notes
// - pin1 field codes off, rise, fall, both
// - pin0 field in low two bits
// - unimplemented bits always read zero
// - three shared groups summarised in primary bank
// - ctrl0 pin flags bits 4,5, enables 1,2
// - ctrl0 converter flag bit6, enable bit3
// - ctrl1 overvoltage flag bit7, enable bit3
// - ctrl1 group flags 4..6, enables 0..2
// - ctrl2 tick, uart0, serial flags and enables
// - ctrl3 second spi and uart1 bits
// - group0 holds standard and periodic0 timers
// - group1 holds periodic timers 1 and 2
// - sources set flags; all bits reset zero
// - global enable low blocks every request
// - disabled flag stays recorded, no request
// - servicing clears the global enable
// - group2 holds low voltage and eeprom
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module irq_bank (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // external pins and peripheral event pulses
  input  wire logic [1:0]  ext_pin_in,
  input  wire logic        converter_done_evt,
  input  wire logic        overvolt_evt,
  input  wire logic [1:0]  time_tick_evt,
  input  wire logic [1:0]  uart_evt,
  input  wire logic        serial_module_evt,
  input  wire logic        second_spi_evt,
  input  wire logic        std_timer_period_evt,
  input  wire logic        std_timer_cmpa_evt,
  input  wire logic [2:0]  periodic_timer_period_evt,
  input  wire logic [2:0]  periodic_timer_cmpa_evt,
  input  wire logic        eeprom_write_done_evt,
  input  wire logic        low_voltage_evt,
  // core side request and vector
  output logic             core_irq_req,
  output logic [3:0]       core_irq_vector,
  input  wire logic        core_irq_ack,
  // summary interrupt of the status layer
  output logic             irq_out
);

  // maps a byte address to a register index, unmapped gives none
  function automatic logic [3:0] addr_index(input logic [7:0] addr);
    logic [3:0] idx;
    idx = irq_bank_pkg::IDX_NONE;
    if (addr[1:0] != 2'h0)
      idx = irq_bank_pkg::IDX_NONE;
    else if (addr <= irq_bank_pkg::OFS_SHARED_IRQ_GROUP_2)
      idx = {1'b0, addr[4:2]};
    else if (addr == irq_bank_pkg::OFS_EVT_STATUS)
      idx = irq_bank_pkg::IDX_STATUS;
    else if (addr == irq_bank_pkg::OFS_EVT_CLEAR)
      idx = irq_bank_pkg::IDX_CLEAR;
    else if (addr == irq_bank_pkg::OFS_EVT_ENABLE)
      idx = irq_bank_pkg::IDX_ENABLE;
    return idx;
  endfunction

  // lowest pending source index wins
  function automatic logic [3:0] pick_source(input logic [12:0] pend);
    logic [3:0] sel;
    sel = 4'h0;
    for (int k = irq_bank_pkg::NUM_SRC - 1; k >= 0; k--)
      if (pend[k])
        sel = 4'(k);
    return sel;
  endfunction

  // register bank and pin history
  logic [7:0]  bank_ff [irq_bank_pkg::NUM_REGS];   // interrupt control registers
  logic [7:0]  nxt_bank [irq_bank_pkg::NUM_REGS];  // next value per register
  logic [7:0]  hw_set [irq_bank_pkg::NUM_REGS];    // flag bits raised by sources
  logic [7:0]  hw_clr [irq_bank_pkg::NUM_REGS];    // bits dropped by servicing
  logic [1:0]  pin_prev_ff;                         // pin level one cycle ago

  // bus write path state
  logic        aw_got_ff;        // write address held
  logic        w_got_ff;         // write data held
  logic [7:0]  awaddr_ff;        // held write address
  logic [7:0]  wdata_ff;         // held write data byte
  logic        wstrb0_ff;        // low lane strobe of held data
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  // bus read path state
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  // core side and event layer state
  logic        req_ff;           // request presented to the core
  logic [3:0]  vector_ff;        // vector of the presented request
  logic [irq_bank_pkg::EVT_W-1:0] evt_stat_ff;  // sticky events
  logic [irq_bank_pkg::EVT_W-1:0] evt_en_ff;    // event enables
  logic        irq_out_ff;

  // handshakes and decode
  wire         aw_take = s_axi_awvalid & awready_ff;
  wire         w_take = s_axi_wvalid & wready_ff;
  wire         ar_take = s_axi_arvalid & arready_ff;
  wire         wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire [3:0]   wr_idx = addr_index(awaddr_ff);
  wire [3:0]   rd_idx = addr_index(s_axi_araddr);
  wire         wr_bank = wr_fire & wstrb0_ff & ~wr_idx[3];
  wire         nxt_aw_got = (aw_got_ff | aw_take) & ~wr_fire;
  wire         nxt_w_got = (w_got_ff | w_take) & ~wr_fire;
  wire         nxt_bvalid = wr_fire | (bvalid_ff & ~s_axi_bready);
  wire         nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
  wire [1:0]   wr_resp = (wr_idx == irq_bank_pkg::IDX_NONE) ?
                         irq_bank_pkg::RESP_SLVERR : irq_bank_pkg::RESP_OKAY;
  wire [1:0]   rd_resp = (rd_idx == irq_bank_pkg::IDX_NONE) ?
                         irq_bank_pkg::RESP_SLVERR : irq_bank_pkg::RESP_OKAY;

  // edge detection on the external pins
  wire [1:0]   pin_rise = ext_pin_in & ~pin_prev_ff;
  wire [1:0]   pin_fall = ~ext_pin_in & pin_prev_ff;
  wire [1:0]   pin1_edge_field = bank_ff[irq_bank_pkg::IDX_EDGE][3:2];
  wire [1:0]   pin0_edge_field = bank_ff[irq_bank_pkg::IDX_EDGE][1:0];
  // code 0 disables, bit0 picks rising, bit1 picks falling
  wire         pin1_hit = (pin1_edge_field[0] & pin_rise[1])
                        | (pin1_edge_field[1] & pin_fall[1]);
  wire         pin0_hit = (pin0_edge_field[0] & pin_rise[0])
                        | (pin0_edge_field[1] & pin_fall[0]);

  // shared groups: any member flag with its enable set
  wire [2:0]   grp_any;
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_group
      assign grp_any[g] = |(bank_ff[irq_bank_pkg::IDX_GRP0 + g][7:4]
                            & bank_ff[irq_bank_pkg::IDX_GRP0 + g][3:0]);
    end
  endgenerate

  // flag bits raised by sources, per register
  assign hw_set[0] = 8'h00;
  assign hw_set[1] = {1'b0, converter_done_evt, pin1_hit, pin0_hit,
                      4'h0};
  assign hw_set[2] = {overvolt_evt, grp_any, 4'h0};
  assign hw_set[3] = {serial_module_evt, uart_evt[0], time_tick_evt,
                      4'h0};
  assign hw_set[4] = {2'h0, uart_evt[1], second_spi_evt, 4'h0};
  assign hw_set[5] = {periodic_timer_cmpa_evt[0], periodic_timer_period_evt[0],
                      std_timer_cmpa_evt, std_timer_period_evt, 4'h0};
  assign hw_set[6] = {periodic_timer_cmpa_evt[2], periodic_timer_period_evt[2],
                      periodic_timer_cmpa_evt[1], periodic_timer_period_evt[1],
                      4'h0};
  assign hw_set[7] = {2'h0, eeprom_write_done_evt, low_voltage_evt,
                      4'h0};

  // pending primary sources: flag and own enable both set
  wire [12:0]  pend;
  genvar k;
  generate
    for (k = 0; k < irq_bank_pkg::NUM_SRC; k++)
    begin : g_pend
      assign pend[k] = bank_ff[irq_bank_pkg::SRC_REG[k]][irq_bank_pkg::SRC_FLAG[k]]
                     & bank_ff[irq_bank_pkg::SRC_REG[k]][irq_bank_pkg::SRC_EN[k]];
    end
  endgenerate

  wire         global_irq_enable =
    bank_ff[irq_bank_pkg::IDX_CTRL0][irq_bank_pkg::GLOBAL_EN_BIT];
  wire         ack_take = core_irq_ack & req_ff;
  wire         nxt_req = global_irq_enable & (|pend) & ~ack_take;
  wire [3:0]   nxt_vector = pick_source(pend);

  // servicing drops the global enable and the served primary flag
  always_comb
  begin
    for (int r = 0; r < irq_bank_pkg::NUM_REGS; r++)
      hw_clr[r] = 8'h00;
    hw_clr[irq_bank_pkg::IDX_CTRL0][irq_bank_pkg::GLOBAL_EN_BIT] = ack_take;
    for (int s = 0; s < irq_bank_pkg::NUM_SRC; s++)
      if (ack_take && vector_ff == 4'(s))
        hw_clr[irq_bank_pkg::SRC_REG[s]][irq_bank_pkg::SRC_FLAG[s]] = 1'b1;
  end

  // next register values: write, then hardware clear, then set wins
  genvar r;
  generate
    for (r = 0; r < irq_bank_pkg::NUM_REGS; r++)
    begin : g_reg
      wire [7:0] base = (wr_bank && wr_idx[2:0] == 3'(r)) ? wdata_ff : bank_ff[r];
      assign nxt_bank[r] = ((base & ~hw_clr[r]) | hw_set[r])
                           & irq_bank_pkg::IMPL_MASK[r];
    end
  endgenerate

  // event layer: taken vector, pin edge, group flag newly raised
  wire [2:0]   evt_now = {|(hw_set[2][6:4] & ~bank_ff[2][6:4]),
                          pin0_hit | pin1_hit, ack_take};
  wire         evt_clr_wr = wr_fire & wstrb0_ff & (wr_idx == irq_bank_pkg::IDX_CLEAR);
  wire         evt_en_wr = wr_fire & wstrb0_ff & (wr_idx == irq_bank_pkg::IDX_ENABLE);
  wire [2:0]   evt_clr_bits = evt_clr_wr ? wdata_ff[2:0] : 3'h0;
  wire [2:0]   nxt_evt_stat = (evt_stat_ff & ~evt_clr_bits) | evt_now;
  wire [2:0]   nxt_evt_en = evt_en_wr ? wdata_ff[2:0] : evt_en_ff;

  // read data selection, narrow data in the low bits
  wire [7:0]   rd_byte = ~rd_idx[3] ? bank_ff[rd_idx[2:0]] :
                         (rd_idx == irq_bank_pkg::IDX_STATUS) ? {5'h00, evt_stat_ff} :
                         (rd_idx == irq_bank_pkg::IDX_ENABLE) ? {5'h00, evt_en_ff} :
                         8'h00;

  // interrupt bank registers, all cleared by reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < irq_bank_pkg::NUM_REGS; i++)
        bank_ff[i] <= irq_bank_pkg::REG_RESET;
      pin_prev_ff <= 2'h0;
    end
    else if (ce)
    begin
      for (int i = 0; i < irq_bank_pkg::NUM_REGS; i++)
        bank_ff[i] <= nxt_bank[i];
      pin_prev_ff <= ext_pin_in;
    end
  end

  // write address and data capture, taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end
    else if (ce)
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      if (aw_take)
        awaddr_ff <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_ff <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end
    end
  end

  // write handshake outputs and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= irq_bank_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff <= ~nxt_w_got & ~nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (wr_fire)
        bresp_ff <= wr_resp;
    end
  end

  // read channel: data registered on the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= irq_bank_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_take)
      begin
        rdata_ff <= {24'h00_0000, rd_byte};
        rresp_ff <= rd_resp;
      end
    end
  end

  // request and vector toward the core, event layer and its output
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_ff <= 1'b0;
      vector_ff <= 4'h0;
      evt_stat_ff <= 3'h0;
      evt_en_ff <= 3'h0;
      irq_out_ff <= 1'b0;
    end
    else if (ce)
    begin
      req_ff <= nxt_req;
      vector_ff <= nxt_vector;
      evt_stat_ff <= nxt_evt_stat;
      evt_en_ff <= nxt_evt_en;
      irq_out_ff <= |(nxt_evt_stat & nxt_evt_en);
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign core_irq_req = req_ff;
  assign core_irq_vector = vector_ff;
  assign irq_out = irq_out_ff;

endmodule
`default_nettype wire

// *** shared/irq_bank_pkg.sv ***
package irq_bank_pkg;
  // register byte offsets of the interrupt bank
  localparam logic [7:0] OFS_EXT_EDGE_SELECT    = 8'h00;
  localparam logic [7:0] OFS_PRIMARY_IRQ_CTRL_0 = 8'h04;
  localparam logic [7:0] OFS_PRIMARY_IRQ_CTRL_1 = 8'h08;
  localparam logic [7:0] OFS_PRIMARY_IRQ_CTRL_2 = 8'h0C;
  localparam logic [7:0] OFS_PRIMARY_IRQ_CTRL_3 = 8'h10;
  localparam logic [7:0] OFS_SHARED_IRQ_GROUP_0 = 8'h14;
  localparam logic [7:0] OFS_SHARED_IRQ_GROUP_1 = 8'h18;
  localparam logic [7:0] OFS_SHARED_IRQ_GROUP_2 = 8'h1C;
  // offsets of the bus-side event status layer
  localparam logic [7:0] OFS_EVT_STATUS         = 8'h20;
  localparam logic [7:0] OFS_EVT_CLEAR          = 8'h24;
  localparam logic [7:0] OFS_EVT_ENABLE         = 8'h28;

  // bank geometry
  localparam int NUM_REGS = 8;
  localparam int NUM_SRC  = 13;
  localparam int EVT_W    = 3;

  // register indices inside the bank
  localparam int IDX_EDGE = 0;
  localparam int IDX_CTRL0 = 1;
  localparam int IDX_CTRL1 = 2;
  localparam int IDX_GRP0 = 5;
  localparam logic [3:0] IDX_STATUS = 4'h8;
  localparam logic [3:0] IDX_CLEAR = 4'h9;
  localparam logic [3:0] IDX_ENABLE = 4'hA;
  localparam logic [3:0] IDX_NONE = 4'hF;

  // implemented bits per register, unimplemented bits read zero
  localparam logic [7:0] IMPL_MASK [NUM_REGS] =
    '{8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'hFF, 8'h33};
  // power-on value of every implemented bit
  localparam logic [7:0] REG_RESET = 8'h00;

  // bit positions of the global enable and the pin edge fields
  localparam int GLOBAL_EN_BIT = 0;
  localparam int PIN0_FIELD_LSB = 0;
  localparam int PIN1_FIELD_LSB = 2;

  // edge field codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // primary sources in priority order: register, flag bit, enable bit
  localparam int SRC_REG [NUM_SRC] = '{1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4};
  localparam int SRC_FLAG [NUM_SRC] = '{4, 5, 6, 4, 5, 6, 7, 4, 5, 6, 7, 4, 5};
  localparam int SRC_EN [NUM_SRC] = '{1, 2, 3, 0, 1, 2, 3, 0, 1, 2, 3, 0, 1};

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** sim/irq_bank_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_bank_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        core_irq_req,
  input wire logic [3:0]  core_irq_vector,
  input wire logic        core_irq_ack
);
  // one clock domain, quiet while reset is held
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_ack_drops_req: assert property
    (ce && core_irq_req && core_irq_ack |=> !core_irq_req)
    else $error("request still high after it was taken");
  a_vector_range: assert property
    (core_irq_req |-> core_irq_vector <= 4'hC)
    else $error("vector outside the source list");
  a_rdata_upper: assert property
    (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_read_latency: assert property
    (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_latency: assert property
    ((ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) ##1 ce
      |=> s_axi_bvalid)
    else $error("write answer not two edges after take");
  a_read_busy: assert property
    (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  a_write_busy: assert property
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  a_error_zero: assert property
    (s_axi_rvalid && s_axi_rresp == irq_bank_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
endmodule
bind irq_bank irq_bank_checker u_irq_bank_checker (
  .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .core_irq_req, .core_irq_vector, .core_irq_ack
);
`default_nettype wire

// *** sim/core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       req,
  input  wire logic [3:0] vector,
  input  wire logic       ack_on,
  input  wire logic       slow,
  output logic            ack_ff,
  output logic [3:0]      vec_ff,
  output logic [7:0]      cnt_ff
);
  logic [1:0] wait_ff;  // cycles spent before a slow take

  // take a pending request at once or after three waits, one-cycle ack
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ack_ff  <= 1'h0;
      vec_ff  <= 4'h0;
      cnt_ff  <= 8'h00;
      wait_ff <= 2'h0;
    end
    else
    begin
      ack_ff <= 1'h0;
      if (req && ack_on && !ack_ff && (!slow || wait_ff == 2'h3))
      begin
        ack_ff  <= 1'h1;  // take the presented request
        vec_ff  <= vector;  // vector being served
        cnt_ff  <= cnt_ff + 8'h01;
        wait_ff <= 2'h0;
      end
      else if (req && ack_on && !ack_ff)
        wait_ff <= wait_ff + 2'h1;  // still busy
    end
  end
endmodule
`default_nettype wire

// *** sim/irq_bank_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_bank_test;
  // bus, pin and event drivers
  logic        aclk, aresetn = 1'h0, ack_on = 1'h0, slow = 1'h0, ce = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [1:0]  ext_pin_in = 2'h0;
  logic [17:0] evt = 18'h0;  // one line per peripheral source
  // design outputs
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        core_irq_req, core_irq_ack, irq_out;
  logic [3:0]  core_irq_vector, taken_vec;
  logic [7:0]  taken_cnt;
  int          num_errors = 0;
  int          checks_done = 0;
  // implemented bits of the eight bank registers
  localparam logic [7:0] MASK [8] = '{8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'hFF, 8'h33};
  // register index times eight plus flag bit, per event line
  localparam int SRC [18] = '{14, 23, 28, 29, 30, 37, 31, 36, 44, 45, 46, 52, 54, 47, 53, 55, 61, 60};
  irq_bank u_irq_bank (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_pin_in, .converter_done_evt(evt[0]),
    .overvolt_evt(evt[1]), .time_tick_evt(evt[3:2]), .uart_evt(evt[5:4]),
    .serial_module_evt(evt[6]), .second_spi_evt(evt[7]), .std_timer_period_evt(evt[8]),
    .std_timer_cmpa_evt(evt[9]), .periodic_timer_period_evt(evt[12:10]),
    .periodic_timer_cmpa_evt(evt[15:13]), .eeprom_write_done_evt(evt[16]),
    .low_voltage_evt(evt[17]), .core_irq_req, .core_irq_vector, .core_irq_ack, .irq_out
  );
  core_model u_core_model (
    .aclk, .aresetn, .req(core_irq_req), .vector(core_irq_vector), .ack_on, .slow,
    .ack_ff(core_irq_ack), .vec_ff(taken_vec), .cnt_ff(taken_cnt)
  );
  // free-running clock
  initial
  begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  // count a comparison, report a mismatch
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one write or read, held until answered, response and data checked
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er = irq_bank_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'hFFFFFF, d};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (n < 50 && !(w ? s_axi_bvalid : s_axi_rvalid));
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    if (w)
      chk({32'h0, s_axi_bvalid, s_axi_bresp}, {32'h0, 1'h1, er});
    else
      chk({s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'h1, er, 24'h0, d});
  endtask
  // wait for the core to take request k, then check its vector
  task automatic take(input logic [7:0] k, input logic [3:0] v);
    int n;
    n = 0;
    while (taken_cnt !== k && n < 50)
    begin
      @(posedge aclk);
      n++;
    end
    chk({23'h0, taken_cnt, taken_vec}, {23'h0, k, v});
  endtask
  // reset values, writable bits, refused addresses
  task automatic t_regs;
    for (int i = 0; i < 8; i++)
    begin
      bus(0, 8'(4 * i), 8'h00);
      bus(1, 8'(4 * i), 8'hFF);
      bus(0, 8'(4 * i), MASK[i]);
    end
    chk({34'h0, core_irq_req}, 35'h1);
    for (int i = 7; i >= 0; i--)
      bus(1, 8'(4 * i), 8'h00);
    repeat (3) @(posedge aclk);
    chk({34'h0, core_irq_req}, 35'h0);
    bus(1, 8'h40, 8'h5A, irq_bank_pkg::RESP_SLVERR);
    bus(0, 8'h40, 8'h00, irq_bank_pkg::RESP_SLVERR);
    bus(0, 8'h02, 8'h00, irq_bank_pkg::RESP_SLVERR);
    bus(0, 8'h24, 8'h00);
  endtask
  // every edge code on each pin, rising then falling
  task automatic t_edges;
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 4; c++)
      begin
        bus(1, 8'h00, 8'(c << (2 * p)));
        ext_pin_in <= 2'(1 << p);
        repeat (2) @(posedge aclk);
        bus(0, 8'h04, c[0] ? 8'(16 << p) : 8'h00);
        bus(1, 8'h04, 8'h00);
        ext_pin_in <= 2'h0;
        repeat (2) @(posedge aclk);
        bus(0, 8'h04, c[1] ? 8'(16 << p) : 8'h00);
        bus(1, 8'h04, 8'h00);
      end
  endtask
  // each event sets only its own flag and stays recorded while disabled
  task automatic t_src;
    for (int i = 0; i < 18; i++)
    begin
      @(posedge aclk);
      evt <= 18'(1 << i);
      @(posedge aclk);
      evt <= 18'h0;
      bus(0, 8'(4 * (SRC[i] / 8)), 8'(1 << (SRC[i] % 8)));
      bus(1, 8'(4 * (SRC[i] / 8)), 8'h00);
    end
    // global enable on, every event line raised, no own enable set
    bus(1, 8'h04, 8'h01);
    evt <= 18'h3FFFF;
    @(posedge aclk);
    evt <= 18'h0;
    repeat (3) @(posedge aclk);
    chk({34'h0, core_irq_req}, 35'h0);
    for (int i = 1; i < 8; i++)
      bus(1, 8'(4 * i), 8'h00);
  endtask
  // a low clock enable holds the overvoltage flag still
  task automatic t_freeze;
    @(posedge aclk);
    ce <= 1'h0;
    evt <= 18'h00002;
    @(posedge aclk);
    evt <= 18'h0;
    ce <= 1'h1;
    bus(0, 8'h08, 8'h00);
  endtask
  // group and direct requests served in priority order, status interrupt
  task automatic t_service;
    bus(1, 8'h1C, 8'h01);
    evt <= 18'h20002;
    @(posedge aclk);
    evt <= 18'h0;
    bus(0, 8'h08, 8'hC0);
    bus(1, 8'h08, 8'hCC);
    repeat (3) @(posedge aclk);
    chk({34'h0, core_irq_req}, 35'h0);
    bus(1, 8'h28, 8'h01);
    ack_on <= 1'h1;
    slow <= 1'h1;
    bus(1, 8'h04, 8'h01);
    take(8'h01, 4'h5);
    bus(0, 8'h04, 8'h00);
    bus(0, 8'h08, 8'hCC);
    chk({34'h0, irq_out}, 35'h1);
    bus(1, 8'h28, 8'h00);
    chk({34'h0, irq_out}, 35'h0);
    bus(1, 8'h28, 8'h01);
    bus(0, 8'h20, 8'h07);
    bus(1, 8'h24, 8'h07);
    chk({34'h0, irq_out}, 35'h0);
    bus(0, 8'h20, 8'h00);
    bus(0, 8'h28, 8'h01);
    bus(1, 8'h1C, 8'h01);
    bus(1, 8'h08, 8'h8C);
    slow <= 1'h0;
    bus(1, 8'h04, 8'h01);
    take(8'h02, 4'h6);
    bus(0, 8'h08, 8'h0C);
  endtask
  // verdict and end of run
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    end_sim();
  end
  // reset, then the scenarios
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_edges();
    t_src();
    t_freeze();
    t_service();
    end_sim();
  end
endmodule
`default_nettype wire
